// ===== ata_cmd_pkg.sv
`default_nettype none
package ata_cmd_pkg;
   // Opcodes
   localparam logic [7:0] OP_HEALTH      = 8'hB0;
   localparam logic [7:0] OP_SET_FEAT    = 8'hEF;
   localparam logic [7:0] OP_SANITIZE    = 8'hB4;
   localparam logic [7:0] OP_QUEUED_ND   = 8'h63;
   localparam logic [7:0] OP_PWR_CHECK   = 8'hE5;
   localparam logic [7:0] OP_PWR_CHECK_A = 8'h98;
   // Health-monitoring subcommands
   localparam logic [7:0] HM_FIRST       = 8'hD0;
   localparam logic [7:0] HM_LAST_DATA   = 8'hD6;
   localparam logic [7:0] HM_ENABLE      = 8'hD8;
   localparam logic [7:0] HM_DISABLE     = 8'hD9;
   localparam logic [7:0] HM_STATUS      = 8'hDA;
   localparam logic [7:0] HM_AUTO_OFF    = 8'hDB;
   // Set-features subcommands
   localparam logic [7:0] SF_WC_EN       = 8'h02;
   localparam logic [7:0] SF_WC_DIS      = 8'h82;
   localparam logic [7:0] SF_RLA_EN      = 8'hAA;
   localparam logic [7:0] SF_RLA_DIS     = 8'h55;
   localparam logic [7:0] SF_PM_EN       = 8'h05;
   localparam logic [7:0] SF_PM_DIS      = 8'h85;
   localparam logic [7:0] SF_PUS_EN      = 8'h06;
   localparam logic [7:0] SF_PUS_DIS     = 8'h86;
   localparam logic [7:0] SF_SPIN_UP     = 8'h07;
   localparam logic [7:0] SF_REV_EN      = 8'hCC;
   localparam logic [7:0] SF_REV_DIS     = 8'h66;
   localparam logic [7:0] SF_XFER_MODE   = 8'h03;
   // Sanitize subcommands (16-bit feature)
   localparam logic [15:0] SN_STATUS     = 16'h0000;
   localparam logic [15:0] SN_OVERWRITE  = 16'h0014;
   localparam logic [15:0] SN_FREEZE     = 16'h0020;
   // Queued non-data subcommands
   localparam logic [7:0] QN_ABORT_ALL   = 8'h00;
   localparam logic [7:0] QN_ABORT_STRM  = 8'h10;
   localparam logic [7:0] QN_ABORT_NSTRM = 8'h20;
   localparam logic [7:0] QN_ABORT_SEL   = 8'h30;
   localparam logic [7:0] QN_DL_WR_SET   = 8'h11;
   localparam logic [7:0] QN_DL_RD_SET   = 8'h21;
   localparam logic [7:0] QN_DL_CLEAR    = 8'h01;
   // Protocol classes
   localparam logic [2:0] PROTO_NONE     = 3'h0;
   localparam logic [2:0] PROTO_PIO_IN   = 3'h1;
   localparam logic [2:0] PROTO_PIO_OUT  = 3'h2;
   localparam logic [2:0] PROTO_NON_DATA = 3'h3;
   localparam logic [2:0] PROTO_DMA      = 3'h4;
   localparam logic [2:0] PROTO_DMA_Q    = 3'h5;
   // Device/head bit positions
   localparam int DH_LBA_BIT = 6;
   localparam int DH_DEV_BIT = 4;
   localparam int DH_RETRY_BIT = 7;
   // Power report codes
   localparam logic [7:0] PC_IDLE_LEGACY = 8'hFF;
   localparam logic [7:0] PC_STANDBY_LEG = 8'h00;
   localparam logic [7:0] PC_IDLE_A      = 8'h81;
   localparam logic [7:0] PC_IDLE_B      = 8'h82;
   localparam logic [7:0] PC_IDLE_C      = 8'h83;
   localparam logic [7:0] PC_STANDBY_Y   = 8'h01;
   localparam logic [7:0] PC_STANDBY_Z   = 8'h00;
   // Status and error bits
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_ERR = 0;
   localparam int ER_ABT = 2;
   localparam logic [7:0] STATUS_RESET = 8'h50;
   localparam logic [7:0] ERROR_RESET  = 8'h00;
   // Decode latency in cycles
   localparam int EXEC_CYCLES = 2;
   // Power conditions of the drive
   typedef enum logic [2:0] {
      PWR_IDLE_A, PWR_IDLE_B, PWR_IDLE_C, PWR_STANDBY_Y, PWR_STANDBY_Z
   } pwr_cond_t;
   // Register-bus offsets for the host controller
   localparam logic [3:0] HR_FEATURE  = 4'h0;
   localparam logic [3:0] HR_FEAT_EXT = 4'h1;
   localparam logic [3:0] HR_DEVHEAD  = 4'h2;
   localparam logic [3:0] HR_COMMAND  = 4'h3;
   localparam logic [3:0] HR_STATUS   = 4'h4;
   localparam logic [3:0] HR_ERROR    = 4'h5;
   localparam logic [3:0] HR_COUNT    = 4'h6;
   localparam logic [3:0] HR_PROTO    = 4'h7;
   localparam logic [3:0] HR_IRQ_STAT = 4'h8;
   localparam logic [3:0] HR_IRQ_MASK = 4'h9;
endpackage : ata_cmd_pkg
`default_nettype wire

// ===== ata_cmd_if.sv
`default_nettype none
interface ata_cmd_if;
   // Command block toward the drive
   logic       cmd_valid;
   logic [7:0] cmd_opcode;
   logic [15:0] cmd_feature;
   logic [7:0] cmd_devhead;
   // Completion from the drive
   logic       done_irq;
   logic [7:0] done_status;
   logic [7:0] done_error;
   logic [7:0] done_count;
   logic [2:0] done_proto;
   modport drive (input cmd_valid, cmd_opcode, cmd_feature, cmd_devhead,
                  output done_irq, done_status, done_error, done_count, done_proto);
   modport host  (output cmd_valid, cmd_opcode, cmd_feature, cmd_devhead,
                  input done_irq, done_status, done_error, done_count, done_proto);
endinterface : ata_cmd_if
`default_nettype wire

// ===== ata_cmd_drive.sv
`default_nettype none
// Function
// [RL1] Health subcommands D0-D6, D8-DB decoded
// [RL2] Set-features codes decoded per table
// [RL3] Sanitize 16-bit feature: 0000, 0014, 0020
// [RL4] Queued abort variants 00,10,20,30
// [RL5] Deadline options set 11/21, clear 01
// [RL6] Each opcode reports protocol class 1-5
// [RL7] Alternate opcodes behave identically
// [RL8] Power check from E5h or 98h
// [RL9] Device/head bit 4 ignored
// [RL10] Always behaves as device 0
// [RL11] LBA bit selects CHS or LBA
// [RL12] Retry bit ignored, host writes 0
// [RL13] Status final when interrupt raised
// [RL14] Power check leaves state undisturbed
// [RL15] Idle legacy reports FFh
// [RL16] Standby legacy reports 00h
// [RL17] Extended conditions report 81-83,01,00
// [RL18] Unsupported codes abort with error
module ata_cmd_drive (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Host link
   ata_cmd_if.drive                    link,
   // Drive-side state
   input  wire ata_cmd_pkg::pwr_cond_t power_cond,
   input  wire logic                   epc_enabled,
   output logic                        write_cache_on,
   output logic                        read_ahead_on,
   output logic                        apm_on,
   output logic                        pus_on,
   output logic                        revert_on,
   output logic                        health_on,
   output logic                        auto_offline_on,
   output logic                        wr_deadline_on,
   output logic                        rd_deadline_on,
   output logic                        lba_mode,
   output logic                        sanitize_frozen,
   output logic                        sub_pulse,
   output logic [7:0]                  sub_code
);
   import ata_cmd_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_EXEC, S_DONE} state_t;
   state_t     state;
   logic [1:0] wait_cnt;
   logic [7:0] op;
   logic [15:0] feat;
   logic       known;
   logic [2:0] proto;

   // Alternate opcodes fold onto their primary code
   function automatic logic [7:0] fold(input logic [7:0] o);
      fold = (o == OP_PWR_CHECK_A) ? OP_PWR_CHECK : o; // RL7 RL8
   endfunction : fold

   // Subcommand legality and protocol class
   always_comb begin
      known = 1'b0;
      proto = PROTO_NONE;
      unique case (op)
         OP_HEALTH: begin
            if (feat[7:0] >= HM_FIRST && feat[7:0] <= HM_LAST_DATA) begin // RL1
               known = 1'b1;
               proto = (feat[7:0] == 8'hD0 || feat[7:0] == 8'hD1 || feat[7:0] == 8'hD5)
                       ? PROTO_PIO_IN
                       : (feat[7:0] == HM_LAST_DATA) ? PROTO_PIO_OUT : PROTO_NON_DATA; // RL6
            end else if (feat[7:0] >= HM_ENABLE && feat[7:0] <= HM_AUTO_OFF) begin // RL1
               known = 1'b1;
               proto = PROTO_NON_DATA;
            end
         end
         OP_SET_FEAT: begin
            unique case (feat[7:0]) // RL2
               SF_WC_EN, SF_WC_DIS, SF_RLA_EN, SF_RLA_DIS, SF_PM_EN, SF_PM_DIS,
               SF_PUS_EN, SF_PUS_DIS, SF_SPIN_UP, SF_REV_EN, SF_REV_DIS,
               SF_XFER_MODE: known = 1'b1;
               default:      known = 1'b0;
            endcase
            proto = PROTO_NON_DATA;
         end
         OP_SANITIZE: begin
            known = (feat == SN_STATUS) || (feat == SN_OVERWRITE) || (feat == SN_FREEZE); // RL3
            proto = PROTO_NON_DATA;
         end
         OP_QUEUED_ND: begin
            unique case (feat[7:0]) // RL4 RL5
               QN_ABORT_ALL, QN_ABORT_STRM, QN_ABORT_NSTRM, QN_ABORT_SEL,
               QN_DL_WR_SET, QN_DL_RD_SET, QN_DL_CLEAR: known = 1'b1;
               default: known = 1'b0;
            endcase
            proto = PROTO_NON_DATA;
         end
         OP_PWR_CHECK: begin
            known = 1'b1;
            proto = PROTO_NON_DATA;
         end
         default: begin
            known = 1'b0; // RL18
            proto = PROTO_NONE;
         end
      endcase
   end

   // Command capture and sequencing
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state    <= S_IDLE;
         wait_cnt <= 2'h0;
         op       <= 8'h00;
         feat     <= 16'h0000;
      end else begin
         unique case (state)
            S_IDLE: if (link.cmd_valid) begin
               op       <= fold(link.cmd_opcode);
               feat     <= link.cmd_feature;
               wait_cnt <= 2'(EXEC_CYCLES - 1);
               state    <= S_EXEC;
            end
            S_EXEC: if (wait_cnt == 2'h0) begin
               state <= S_DONE;
            end else begin
               wait_cnt <= wait_cnt - 2'h1;
            end
            S_DONE: state <= S_IDLE;
         endcase
      end
   end

   // Device/head: bit 4 and retry ignored, only the LBA bit is kept
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lba_mode <= 1'b0;
      end else if (state == S_IDLE && link.cmd_valid) begin
         lba_mode <= link.cmd_devhead[DH_LBA_BIT]; // RL11 RL9 RL10 RL12
      end
   end

   // Feature state updates on completion of a legal subcommand
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         write_cache_on  <= 1'b1;
         read_ahead_on   <= 1'b1;
         apm_on          <= 1'b0;
         pus_on          <= 1'b0;
         revert_on       <= 1'b0;
         health_on       <= 1'b1;
         auto_offline_on <= 1'b0;
         wr_deadline_on  <= 1'b0;
         rd_deadline_on  <= 1'b0;
         sanitize_frozen <= 1'b0;
      end else if (state == S_DONE && known) begin
         if (op == OP_SET_FEAT) begin
            if (feat[7:0] == SF_WC_EN) write_cache_on <= 1'b1; // RL2
            if (feat[7:0] == SF_WC_DIS) write_cache_on <= 1'b0;
            if (feat[7:0] == SF_RLA_EN) read_ahead_on <= 1'b1;
            if (feat[7:0] == SF_RLA_DIS) read_ahead_on <= 1'b0;
            if (feat[7:0] == SF_PM_EN) apm_on <= 1'b1;
            if (feat[7:0] == SF_PM_DIS) apm_on <= 1'b0;
            if (feat[7:0] == SF_PUS_EN) pus_on <= 1'b1;
            if (feat[7:0] == SF_PUS_DIS) pus_on <= 1'b0;
            if (feat[7:0] == SF_REV_EN) revert_on <= 1'b1;
            if (feat[7:0] == SF_REV_DIS) revert_on <= 1'b0;
         end
         if (op == OP_HEALTH) begin
            if (feat[7:0] == HM_ENABLE) health_on <= 1'b1; // RL1
            if (feat[7:0] == HM_DISABLE) health_on <= 1'b0;
            if (feat[7:0] == HM_AUTO_OFF) auto_offline_on <= ~auto_offline_on;
         end
         if (op == OP_QUEUED_ND) begin
            if (feat[7:0] == QN_DL_WR_SET) wr_deadline_on <= 1'b1; // RL5
            if (feat[7:0] == QN_DL_RD_SET) rd_deadline_on <= 1'b1;
            if (feat[7:0] == QN_DL_CLEAR) begin
               wr_deadline_on <= 1'b0;
               rd_deadline_on <= 1'b0;
            end
         end
         if (op == OP_SANITIZE && feat == SN_FREEZE) sanitize_frozen <= 1'b1; // RL3
      end
   end

   // Subcommand pulse toward the drive's engines
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sub_pulse <= 1'b0;
         sub_code  <= 8'h00;
      end else begin
         sub_pulse <= (state == S_DONE) && known && (op != OP_PWR_CHECK);
         if (state == S_DONE) sub_code <= feat[7:0];
      end
   end

   // Completion registers, final together with the interrupt
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link.done_irq    <= 1'b0;
         link.done_status <= STATUS_RESET;
         link.done_error  <= ERROR_RESET;
         link.done_count  <= 8'h00;
         link.done_proto  <= PROTO_NONE;
      end else begin
         link.done_irq <= (state == S_DONE); // RL13
         if (state == S_IDLE && link.cmd_valid) begin
            link.done_status <= 8'h80; // Busy while decoding
         end else if (state == S_DONE) begin
            link.done_proto  <= proto; // RL6
            link.done_error  <= known ? 8'h00 : (8'h01 << ER_ABT); // RL18
            link.done_status <= known ? STATUS_RESET : (STATUS_RESET | 8'h01); // RL13
            if (op == OP_PWR_CHECK) begin // RL14
               if (!epc_enabled) begin
                  link.done_count <= (power_cond == PWR_STANDBY_Y ||
                                      power_cond == PWR_STANDBY_Z)
                                     ? PC_STANDBY_LEG : PC_IDLE_LEGACY; // RL15 RL16
               end else begin
                  unique case (power_cond) // RL17
                     PWR_IDLE_A:    link.done_count <= PC_IDLE_A;
                     PWR_IDLE_B:    link.done_count <= PC_IDLE_B;
                     PWR_IDLE_C:    link.done_count <= PC_IDLE_C;
                     PWR_STANDBY_Y: link.done_count <= PC_STANDBY_Y;
                     default:       link.done_count <= PC_STANDBY_Z;
                  endcase
               end
            end
         end
      end
   end
endmodule : ata_cmd_drive
`default_nettype wire

// ===== ata_cmd_host.sv
`default_nettype none
module ata_cmd_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Software register port
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [7:0]       rdata,
   output logic             irq,
   // Drive link
   ata_cmd_if.host          link
);
   import ata_cmd_pkg::*;

   logic [15:0] feature;
   logic [7:0]  devhead;
   logic [7:0]  status;
   logic [7:0]  error;
   logic [7:0]  count;
   logic [2:0]  proto;
   logic        busy;
   logic [1:0]  irq_stat;
   logic [1:0]  irq_mask;
   logic        issue;

   assign issue = wr && addr == HR_COMMAND && !busy;

   // Command block registers; retry bit forced to 0
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         feature <= 16'h0000;
         devhead <= 8'h00;
      end else if (wr) begin
         if (addr == HR_FEATURE) feature[7:0] <= wdata;
         if (addr == HR_FEAT_EXT) feature[15:8] <= wdata; // RL3
         if (addr == HR_DEVHEAD) devhead <= wdata & 8'h7F; // RL12 RL11
      end
   end

   // Issue strobe to the drive
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link.cmd_valid   <= 1'b0;
         link.cmd_opcode  <= 8'h00;
         link.cmd_feature <= 16'h0000;
         link.cmd_devhead <= 8'h00;
      end else begin
         link.cmd_valid <= issue;
         if (issue) begin
            link.cmd_opcode  <= wdata; // RL1 RL2 RL4 RL5
            link.cmd_feature <= feature;
            link.cmd_devhead <= devhead;
         end
      end
   end

   // Busy window and captured completion
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy   <= 1'b0;
         status <= STATUS_RESET;
         error  <= ERROR_RESET;
         count  <= 8'h00;
         proto  <= PROTO_NONE;
      end else begin
         if (issue) busy <= 1'b1;
         else if (link.done_irq) busy <= 1'b0;
         if (link.done_irq) begin
            status <= link.done_status;
            error  <= link.done_error;
            count  <= link.done_count;
            proto  <= link.done_proto;
         end
      end
   end

   // Interrupt status: bit0 done, bit1 error; set wins over clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end else begin
         if (wr && addr == HR_IRQ_MASK) irq_mask <= wdata[1:0];
         irq_stat <= (irq_stat & ~((wr && addr == HR_IRQ_STAT) ? wdata[1:0] : 2'h0))
                     | (link.done_irq ? {link.done_status[ST_ERR], 1'b1} : 2'h0);
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // Read data one cycle after the strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            HR_FEATURE:  rdata <= feature[7:0];
            HR_FEAT_EXT: rdata <= feature[15:8];
            HR_DEVHEAD:  rdata <= devhead;
            HR_STATUS:   rdata <= busy ? 8'h80 : status;
            HR_ERROR:    rdata <= error;
            HR_COUNT:    rdata <= count;
            HR_PROTO:    rdata <= {5'h00, proto};
            HR_IRQ_STAT: rdata <= {6'h00, irq_stat};
            HR_IRQ_MASK: rdata <= {6'h00, irq_mask};
            default:     rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule : ata_cmd_host
`default_nettype wire

// ===== ata_cmd_assertions.sv
`default_nettype none
module ata_cmd_assertions (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Command block
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_opcode,
   input wire logic [15:0] cmd_feature,
   input wire logic [7:0]  cmd_devhead,
   // Completion
   input wire logic        done_irq,
   input wire logic [7:0]  done_status,
   input wire logic [7:0]  done_error,
   input wire logic [7:0]  done_count,
   input wire logic [2:0]  done_proto
);
   import ata_cmd_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [7:0]  op_q;
   logic [15:0] ft_q;
   // Remember the command being answered
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         op_q <= 8'h00;
         ft_q <= 16'h0000;
      end else if (cmd_valid) begin
         op_q <= cmd_opcode;
         ft_q <= cmd_feature;
      end
   end
   a_answer_four: assert property (cmd_valid |-> ##4 done_irq)
      else $error("completion not four cycles after command");
   a_busy_shown: assert property (cmd_valid |=> (done_status == 8'h80) [*3])
      else $error("busy status not shown while executing");
   a_pulse_single: assert property (done_irq |=> !done_irq && $stable(done_status))
      else $error("completion pulse too long or status moved");
   a_irq_caused: assert property (done_irq |-> $past(cmd_valid, 4))
      else $error("completion without a command");
   a_abort_form: assert property (done_irq |-> (done_status[ST_ERR] ?
      (done_status == 8'h51 && done_error == 8'h04) :
      (done_status == 8'h50 && done_error == 8'h00)))
      else $error("status and error disagree");
   a_pwr_clean: assert property (done_irq && (op_q == 8'hE5 || op_q == 8'h98)
      |-> !done_status[ST_ERR])
      else $error("power check refused");
   a_queued_ok: assert property (done_irq && op_q == 8'h63 && ft_q[15:8] == 8'h00 &&
      ft_q[7:0] inside {8'h00, 8'h10, 8'h20, 8'h30, 8'h11, 8'h21, 8'h01}
      |-> done_error == 8'h00)
      else $error("queued subcommand refused");
   a_sanitize_set: assert property (done_irq && op_q == 8'hB4 |-> done_status[ST_ERR] ==
      !(ft_q inside {16'h0000, 16'h0014, 16'h0020}))
      else $error("sanitize decode wrong");
   a_health_class: assert property (done_irq && op_q == 8'hB0 &&
      ft_q inside {16'h00D8, 16'h00D9, 16'h00DA, 16'h00DB} |-> done_proto == 3'h3)
      else $error("health control class wrong");
   a_class_range: assert property (done_irq && !done_status[ST_ERR]
      |-> done_proto inside {[3'h1:3'h5]})
      else $error("protocol class out of range");
   a_retry_zero: assert property (cmd_valid |-> !cmd_devhead[DH_RETRY_BIT])
      else $error("retry bit sent as one");
   c_power: cover property (done_irq && op_q == 8'h98);
   c_abort: cover property (done_irq && done_status[ST_ERR]);
   c_sanitize: cover property (done_irq && op_q == 8'hB4);
endmodule : ata_cmd_assertions
`default_nettype wire

// ===== test_ata_subcommand_power_mode_decoder.sv
`default_nettype none
module test_ata_subcommand_power_mode_decoder;
   timeunit 1ns;
   timeprecision 100ps;
   import ata_cmd_pkg::*;
   logic       clk, reset, wr, rd, irq, epc_enabled;
   logic       wc, ra, apm, pus, rev, hl, ao, wd, rdd, lba, frz, sp;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, sc;
   logic [4:0] lv;
   pwr_cond_t  power_cond;
   int         failures, n_compared;
   assign lv = {rev, pus, apm, ra, wc};
   ata_cmd_if ata_cmd_if_inst ();
   ata_cmd_drive ata_cmd_drive_inst (.clk(clk), .reset(reset), .link(ata_cmd_if_inst),
      .power_cond(power_cond), .epc_enabled(epc_enabled), .write_cache_on(wc),
      .read_ahead_on(ra), .apm_on(apm), .pus_on(pus), .revert_on(rev), .health_on(hl),
      .auto_offline_on(ao), .wr_deadline_on(wd), .rd_deadline_on(rdd), .lba_mode(lba),
      .sanitize_frozen(frz), .sub_pulse(sp), .sub_code(sc));
   ata_cmd_host ata_cmd_host_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .link(ata_cmd_if_inst));
   ata_cmd_assertions ata_cmd_assertions_inst (.clk(clk), .reset(reset),
      .cmd_valid(ata_cmd_if_inst.cmd_valid), .cmd_opcode(ata_cmd_if_inst.cmd_opcode),
      .cmd_feature(ata_cmd_if_inst.cmd_feature), .cmd_devhead(ata_cmd_if_inst.cmd_devhead),
      .done_irq(ata_cmd_if_inst.done_irq), .done_status(ata_cmd_if_inst.done_status),
      .done_error(ata_cmd_if_inst.done_error), .done_count(ata_cmd_if_inst.done_count),
      .done_proto(ata_cmd_if_inst.done_proto));
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Verdict and end of run
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1
   // Software port write and read
   task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : sw_wr
   task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : sw_rd
   // Issue one command, wait for the interrupt, check and clear completion
   task automatic cmd(input logic [7:0] op, input logic [15:0] ft, input logic [7:0] dh,
                      input logic ab, output logic [7:0] cnt, output logic [2:0] pr);
      logic [7:0] v;
      int         k, n = 0;
      sw_wr(HR_FEATURE, ft[7:0]);
      sw_wr(HR_FEAT_EXT, ft[15:8]);
      sw_wr(HR_DEVHEAD, dh);
      sw_wr(HR_COMMAND, op);
      for (k = 0; k < 20 && irq !== 1'b1; k++) begin
         @(posedge clk);
         n += sp;
      end
      if (k == 20) begin
         failures++;
         close_out();
      end
      chk8(sc, ft[7:0]);
      chk8(8'(n), {7'h00, !ab && op != 8'hE5 && op != 8'h98});
      sw_rd(HR_STATUS, v);
      chk8(v, ab ? 8'h51 : 8'h50);
      sw_rd(HR_ERROR, v);
      chk8(v, ab ? 8'h04 : 8'h00);
      sw_rd(HR_IRQ_STAT, v);
      chk8(v, {6'h00, ab, 1'b1});
      sw_rd(HR_COUNT, cnt);
      sw_rd(HR_PROTO, v);
      pr = v[2:0];
      sw_wr(HR_IRQ_STAT, 8'h03);
      @(negedge clk);
      chk1(irq, 1'b0);
   endtask : cmd
   // Reset values and an unmapped read
   task automatic t_reset();
      logic [7:0] v;
      sw_rd(HR_STATUS, v);
      chk8(v, 8'h50);
      sw_rd(4'hF, v);
      chk8(v, 8'h00);
      chk8({2'h0, hl, lv}, 8'h23);
      $display("test reset done");
   endtask : t_reset
   // Health subcommands and their classes
   task automatic t_health();
      logic [7:0] c;
      logic [2:0] p;
      for (int f = 8'hD0; f <= 8'hDC; f++) begin
         if (f == 8'hD9) continue;
         cmd(8'hB0, 16'(f), 8'h40, f == 8'hD7 || f == 8'hDC, c, p);
         if (f != 8'hD7 && f != 8'hDC) chk8({5'h00, p}, f inside {8'hD0, 8'hD1, 8'hD5}
            ? 8'h01 : (f == 8'hD6 ? 8'h02 : 8'h03));
      end
      chk1(ao, 1'b1);
      cmd(8'hB0, 16'h00D9, 8'h40, 1'b0, c, p);
      chk1(hl, 1'b0);
      cmd(8'hB0, 16'h00D8, 8'h40, 1'b0, c, p);
      chk1(hl, 1'b1);
      $display("test health done");
   endtask : t_health
   // Set-features enable and disable pairs
   task automatic t_setfeat();
      logic [7:0] code [10] = '{8'h02, 8'h82, 8'hAA, 8'h55, 8'h05, 8'h85,
                                8'h06, 8'h86, 8'hCC, 8'h66};
      logic [7:0] c;
      logic [2:0] p;
      for (int i = 0; i < 10; i++) begin
         cmd(8'hEF, {8'h00, code[i]}, 8'h40, 1'b0, c, p);
         chk1(lv[i / 2], i % 2 == 0);
      end
      cmd(8'hEF, 16'h0007, 8'h40, 1'b0, c, p);
      cmd(8'hEF, 16'h0003, 8'h40, 1'b0, c, p);
      cmd(8'hEF, 16'h0004, 8'h40, 1'b1, c, p);
      $display("test set features done");
   endtask : t_setfeat
   // Sanitize with a full 16-bit feature
   task automatic t_sanitize();
      logic [7:0] c;
      logic [2:0] p;
      cmd(8'hB4, 16'h0000, 8'h40, 1'b0, c, p);
      cmd(8'hB4, 16'h0014, 8'h40, 1'b0, c, p);
      cmd(8'hB4, 16'h0114, 8'h40, 1'b1, c, p);
      cmd(8'hB4, 16'h0015, 8'h40, 1'b1, c, p);
      chk1(frz, 1'b0);
      cmd(8'hB4, 16'h0020, 8'h40, 1'b0, c, p);
      chk1(frz, 1'b1);
      $display("test sanitize done");
   endtask : t_sanitize
   // Queued aborts and deadline options
   task automatic t_queued();
      logic [7:0] c;
      logic [2:0] p;
      for (int f = 0; f < 4; f++) cmd(8'h63, 16'(f * 16), 8'h40, 1'b0, c, p);
      cmd(8'h63, 16'h0011, 8'h40, 1'b0, c, p);
      cmd(8'h63, 16'h0021, 8'h40, 1'b0, c, p);
      chk8({6'h00, wd, rdd}, 8'h03);
      cmd(8'h63, 16'h0001, 8'h40, 1'b0, c, p);
      chk8({6'h00, wd, rdd}, 8'h00);
      cmd(8'h63, 16'h0040, 8'h40, 1'b1, c, p);
      $display("test queued done");
   endtask : t_queued
   // Power report for every condition, both opcodes, both modes
   task automatic t_power();
      logic [7:0] ext [5] = '{8'h81, 8'h82, 8'h83, 8'h01, 8'h00};
      logic [5:0] s;
      logic [7:0] c;
      logic [2:0] p;
      s = {hl, lv};
      for (int e = 0; e < 2; e++) begin
         for (int pc = 0; pc < 5; pc++) begin
            @(posedge clk);
            epc_enabled <= e[0];
            power_cond <= pwr_cond_t'(pc);
            cmd(pc % 2 ? 8'h98 : 8'hE5, 16'h0000, pc % 2 ? 8'hF0 : 8'h00, 1'b0, c, p);
            chk8(c, e ? ext[pc] : (pc < 3 ? 8'hFF : 8'h00));
            chk8({2'h0, hl, lv}, {2'h0, s});
         end
      end
      $display("test power done");
   endtask : t_power
   // Device/head bits and an unknown opcode
   task automatic t_devhead();
      logic [7:0] c;
      logic [2:0] p;
      cmd(8'hB0, 16'h00DA, 8'h00, 1'b0, c, p);
      chk1(lba, 1'b0);
      cmd(8'hB0, 16'h00DA, 8'hD0, 1'b0, c, p);
      chk1(lba, 1'b1);
      cmd(8'h00, 16'h0000, 8'h40, 1'b1, c, p);
      $display("test device head done");
   endtask : t_devhead
   // Masked completion stays silent until unmasked
   task automatic t_mask();
      logic [7:0] v;
      sw_wr(HR_IRQ_MASK, 8'h00);
      sw_wr(HR_COMMAND, 8'hE5);
      repeat (10) @(posedge clk);
      chk1(irq, 1'b0);
      sw_rd(HR_IRQ_STAT, v);
      chk8(v, 8'h01);
      sw_wr(HR_IRQ_MASK, 8'h01);
      @(negedge clk);
      chk1(irq, 1'b1);
      sw_wr(HR_IRQ_STAT, 8'h01);
      sw_wr(HR_IRQ_MASK, 8'h03);
      @(negedge clk);
      chk1(irq, 1'b0);
      $display("test mask done");
   endtask : t_mask
   // Main sequence
   initial begin
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      epc_enabled = 1'b0;
      power_cond = PWR_IDLE_A;
      failures = 0;
      n_compared = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      sw_wr(HR_IRQ_MASK, 8'h03);
      t_health();
      t_setfeat();
      t_sanitize();
      t_queued();
      t_power();
      t_devhead();
      t_mask();
      close_out();
   end
endmodule : test_ata_subcommand_power_mode_decoder
`default_nettype wire
